// >>> verilog/cdb_defines.vh
// constants shared by the dead-band and blanking generator files
// assumes a 10 MHz system clock and a 32-bit classic wishbone register port
`ifndef CDB_DEFINES_VH
`define CDB_DEFINES_VH

// ==========================================================================
// register byte offsets
`define CDB_OFS_CTRL0     6'h00
`define CDB_OFS_RISE_DB   6'h04
`define CDB_OFS_FALL_DB   6'h08
`define CDB_OFS_RISE_BLK  6'h0C
`define CDB_OFS_FALL_BLK  6'h10
`define CDB_OFS_SHDN_EN   6'h14
`define CDB_OFS_CLK_DIV   6'h18
`define CDB_OFS_STATUS    6'h1C

// ==========================================================================
// generator_control_0 fields
`define CDB_CTRL_EN       0
`define CDB_CTRL_RISING_DELAY_SOURCE_SELECT     1
`define CDB_CTRL_FALLING_DELAY_SOURCE_SELECT     2
`define CDB_CTRL_W        3

// ==========================================================================
// status fields
`define CDB_ST_PRI        0
`define CDB_ST_CMP        1
`define CDB_ST_SHDN       2
`define CDB_ST_RDB_RUN    3
`define CDB_ST_FDB_RUN    4
`define CDB_ST_RBLK_RUN   5
`define CDB_ST_FBLK_RUN   6

// ==========================================================================
// reset values
`define CDB_RST_CTRL0     3'h0
`define CDB_RST_BYTE      8'h00

// ==========================================================================
// timing
`define CDB_DELAY_ELEM_NS 5
`define CDB_CLK_PERIOD_NS 100

`endif

// >>> verilog/cdb_cnt.v
// one tick_i counter (generator periods, or system clocks in async dead band), used for dead band and blanking
// assumes tick_i is a one-cycle enable in the clk_i domain
`timescale 1ns/1ns

module cdb_cnt #(
  parameter W = 8
) (
  input  wire         clk_i,   // system clock
  input  wire         rst_i,   // synchronous reset, high
  input  wire         start_i, // (re)start from zero
  input  wire         clear_i, // abort to idle
  input  wire         tick_i,  // counting enable
  input  wire [W-1:0] limit_i, // periods to count, zero = none
  output wire         run_o,   // counting in progress
  output wire         done_o   // pulse on last period
);
  localparam [W-1:0] ONE = 1;

  reg [W-1:0] cnt;
  reg         run;

  assign run_o  = run;
  assign done_o = run & tick_i & ((cnt + ONE) == limit_i);

  // ==========================================================================
  // counter
  always @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      run <= 1'b0;
      cnt <= {W{1'b0}};
    end else if (start_i) begin
      run <= (limit_i != {W{1'b0}});
      cnt <= {W{1'b0}};
    end else if (done_o) begin
      run <= 1'b0;
      cnt <= {W{1'b0}};
    end else if (run && tick_i) begin
      cnt <= cnt + ONE;
    end
  end
endmodule // cdb_cnt

// >>> verilog/cdb_top.v
// complementary output generator: dead band, input blanking, shutdown
// assumes all inputs synchronous to clk_i; registers on classic wishbone
`timescale 1ns/1ns
`include "cdb_defines.vh"

module cdb_top #(
  parameter W = 8
) (
  input  wire        clk_i,      // system clock, 10 MHz
  input  wire        rst_i,      // synchronous reset, high
  input  wire        wb_cyc_i,   // wishbone cycle
  input  wire        wb_stb_i,   // wishbone strobe
  input  wire        wb_we_i,    // wishbone write
  input  wire [5:0]  wb_adr_i,   // wishbone byte address
  input  wire [3:0]  wb_sel_i,   // wishbone byte selects
  input  wire [31:0] wb_dat_i,   // wishbone write data
  output wire [31:0] wb_dat_o,   // wishbone read data
  output wire        wb_ack_o,   // wishbone acknowledge
  input  wire        gen_in_i,   // generator input signal
  input  wire [7:0]  shdn_src_i, // shutdown source outputs
  output wire        primary_o,  // primary drive
  output wire        compl_o,    // complementary drive
  output wire        shutdown_o  // shutdown active
);
  // ==========================================================================
  // registers
  reg [`CDB_CTRL_W-1:0] generator_control_0;
  reg [W-1:0]           rising_deadband_count;
  reg [W-1:0]           falling_deadband_count;
  reg [W-1:0]           rising_blank_count;
  reg [W-1:0]           falling_blank_count;
  reg [7:0]             shutdown_source_enable_1;
  reg [W-1:0]           gen_clk_div;
  reg                   ack;
  reg [31:0]            rd_data;
  reg [31:0]            next_rd_data;

  // ==========================================================================
  // generator state
  reg         in_q;
  reg         primary;
  reg         compl;
  reg [W-1:0] div_cnt;
  reg         gen_tick;

  wire enable    = generator_control_0[`CDB_CTRL_EN];
  wire rise_async = generator_control_0[`CDB_CTRL_RISING_DELAY_SOURCE_SELECT];
  wire fall_async = generator_control_0[`CDB_CTRL_FALLING_DELAY_SOURCE_SELECT];

  // ceiling of elements * element time over clock period; short chains still
  // cost one whole cycle since the logic cannot resolve below the clock
  function [W-1:0] async_cycles;
    input [W-1:0] n;
    reg   [31:0]  t;
    begin
      t = (n * `CDB_DELAY_ELEM_NS + `CDB_CLK_PERIOD_NS - 1) / `CDB_CLK_PERIOD_NS;
      async_cycles = t[W-1:0];
    end
  endfunction

  // counter limit of one band: chain length in clocks, or generator periods
  function [W-1:0] band_limit;
    input         async_sel;
    input [W-1:0] n;
    begin
      if (async_sel) begin
        band_limit = async_cycles(n);
      end else begin
        band_limit = n;
      end
    end
  endfunction

  // a zero count removes the band, so the drive follows its event at once
  function band_off;
    input [W-1:0] n;
    begin
      band_off = (n == {W{1'b0}});
    end
  endfunction

  // ==========================================================================
  // wishbone slave: ack one cycle after request, dropped the cycle after
  // writes land on the taking edge, the same edge that raises ack
  wire req = wb_cyc_i & wb_stb_i & ~ack;
  wire wr  = req & wb_we_i & wb_sel_i[0];

  assign wb_ack_o = ack;
  assign wb_dat_o = rd_data;

  always @(posedge clk_i) begin
    if (rst_i) begin
      generator_control_0      <= `CDB_RST_CTRL0;
      rising_deadband_count    <= `CDB_RST_BYTE;
      falling_deadband_count   <= `CDB_RST_BYTE;
      rising_blank_count       <= `CDB_RST_BYTE;
      falling_blank_count      <= `CDB_RST_BYTE;
      shutdown_source_enable_1 <= `CDB_RST_BYTE;
      gen_clk_div              <= `CDB_RST_BYTE;
      ack                      <= 1'b0;
      rd_data                  <= 32'h0000_0000;
    end else begin
      ack     <= req;
      rd_data <= req ? next_rd_data : 32'h0000_0000;
      if (wr) begin
        case (wb_adr_i)
          `CDB_OFS_CTRL0: begin
            generator_control_0 <= wb_dat_i[`CDB_CTRL_W-1:0];
          end
          `CDB_OFS_RISE_DB: begin
            rising_deadband_count <= wb_dat_i[W-1:0];
          end
          `CDB_OFS_FALL_DB: begin
            falling_deadband_count <= wb_dat_i[W-1:0];
          end
          `CDB_OFS_RISE_BLK: begin
            rising_blank_count <= wb_dat_i[W-1:0];
          end
          `CDB_OFS_FALL_BLK: begin
            falling_blank_count <= wb_dat_i[W-1:0];
          end
          `CDB_OFS_SHDN_EN: begin
            shutdown_source_enable_1 <= wb_dat_i[7:0];
          end
          `CDB_OFS_CLK_DIV: begin
            gen_clk_div <= wb_dat_i[W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  wire rdb_run;
  wire fdb_run;
  wire rblk_run;
  wire fblk_run;

  // unmapped and write-only-less addresses read as zero
  always @* begin
    next_rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `CDB_OFS_CTRL0:    next_rd_data[`CDB_CTRL_W-1:0] = generator_control_0;
      `CDB_OFS_RISE_DB:  next_rd_data[W-1:0] = rising_deadband_count;
      `CDB_OFS_FALL_DB:  next_rd_data[W-1:0] = falling_deadband_count;
      `CDB_OFS_RISE_BLK: next_rd_data[W-1:0] = rising_blank_count;
      `CDB_OFS_FALL_BLK: next_rd_data[W-1:0] = falling_blank_count;
      `CDB_OFS_SHDN_EN:  next_rd_data[7:0] = shutdown_source_enable_1;
      `CDB_OFS_CLK_DIV:  next_rd_data[W-1:0] = gen_clk_div;
      `CDB_OFS_STATUS: begin
        next_rd_data[`CDB_ST_PRI]      = primary;
        next_rd_data[`CDB_ST_CMP]      = compl;
        next_rd_data[`CDB_ST_SHDN]     = shutdown_o;
        next_rd_data[`CDB_ST_RDB_RUN]  = rdb_run;
        next_rd_data[`CDB_ST_FDB_RUN]  = fdb_run;
        next_rd_data[`CDB_ST_RBLK_RUN] = rblk_run;
        next_rd_data[`CDB_ST_FBLK_RUN] = fblk_run;
      end
      default: next_rd_data = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // generator clock: one-cycle enable every gen_clk_div+1 system cycles
  // compared with >= so a divider lowered below the running count ticks at
  // once instead of wrapping through the whole counter range first
  always @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt  <= {W{1'b0}};
      gen_tick <= 1'b0;
    end else if (div_cnt >= gen_clk_div) begin
      div_cnt  <= {W{1'b0}};
      gen_tick <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + {{(W-1){1'b0}}, 1'b1};
      gen_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // shutdown: any enabled source that is low forces shutdown
  // combinational, so a source dropping low clears the drives at the next edge
  assign shutdown_o = |(shutdown_source_enable_1 & ~shdn_src_i);

  wire halt = shutdown_o | ~enable;

  // ==========================================================================
  // event detection with cross-coupled blanking
  always @(posedge clk_i) begin
    if (rst_i) begin
      in_q <= 1'b0;
    end else begin
      in_q <= gen_in_i;
    end
  end

  // an edge met while halted or blanked is lost, never held over
  wire rise_evt = ~halt & gen_in_i & ~in_q & ~fblk_run;
  wire fall_evt = ~halt & ~gen_in_i & in_q & ~rblk_run;

  // async mode counts system clocks over the rounded chain length;
  // sync mode counts generator clocks so edges land on its grid (+-1 period)
  wire [W-1:0] rdb_lim  = band_limit(rise_async, rising_deadband_count);
  wire [W-1:0] fdb_lim  = band_limit(fall_async, falling_deadband_count);
  wire         rdb_tick = rise_async | gen_tick;
  wire         fdb_tick = fall_async | gen_tick;
  wire         rdb_done;
  wire         fdb_done;

  // an opposite event aborts a running band: the suppressed drive never rises
  cdb_cnt #(.W(W)) u_rdb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (rise_evt),
    .clear_i (halt | fall_evt),
    .tick_i  (rdb_tick),
    .limit_i (rdb_lim),
    .run_o   (rdb_run),
    .done_o  (rdb_done)
  );

  cdb_cnt #(.W(W)) u_fdb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (fall_evt),
    .clear_i (halt | rise_evt),
    .tick_i  (fdb_tick),
    .limit_i (fdb_lim),
    .run_o   (fdb_run),
    .done_o  (fdb_done)
  );

  cdb_cnt #(.W(W)) u_rblk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (rise_evt),
    .clear_i (halt),
    .tick_i  (gen_tick),
    .limit_i (rising_blank_count),
    .run_o   (rblk_run),
    .done_o  ()
  );

  cdb_cnt #(.W(W)) u_fblk (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (fall_evt),
    .clear_i (halt),
    .tick_i  (gen_tick),
    .limit_i (falling_blank_count),
    .run_o   (fblk_run),
    .done_o  ()
  );

  // ==========================================================================
  // drives: the opposite side drops at once, this side waits its band
  // halt wins over every event so shutdown can never be overridden
  always @(posedge clk_i) begin
    if (rst_i || halt) begin
      primary <= 1'b0;
      compl   <= 1'b0;
    end else if (rise_evt) begin
      compl   <= 1'b0;
      primary <= band_off(rising_deadband_count);
    end else if (fall_evt) begin
      primary <= 1'b0;
      compl   <= band_off(falling_deadband_count);
    end else begin
      if (rdb_done) begin
        primary <= 1'b1;
      end
      if (fdb_done) begin
        compl <= 1'b1;
      end
    end
  end

  assign primary_o = primary;
  assign compl_o   = compl;
endmodule // cdb_top

// >>> tb/cdb_top_monitor.sv
// checker on the generator ports: bus answer, drive overlap, shutdown
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns

module cdb_top_monitor #(
  parameter W = 8
) (
  input wire        clk_i,      // clock
  input wire        rst_i,      // reset
  input wire        wb_cyc_i,   // cycle
  input wire        wb_stb_i,   // strobe
  input wire        wb_we_i,    // write
  input wire [5:0]  wb_adr_i,   // address
  input wire [3:0]  wb_sel_i,   // selects
  input wire [31:0] wb_dat_i,   // write data
  input wire [31:0] wb_dat_o,   // read data
  input wire        wb_ack_o,   // ack
  input wire        gen_in_i,   // event input
  input wire [7:0]  shdn_src_i, // sources
  input wire        primary_o,  // primary
  input wire        compl_o,    // complementary
  input wire        shutdown_o  // shutdown
);
  // ========
  // shadow copies, written on the edge where the design takes a write
  logic       en;
  logic [7:0] sd_en;
  wire        wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & wb_sel_i[0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      en    <= 1'b0;
      sd_en <= 8'h00;
    end else if (wr && wb_adr_i == 6'h00) begin
      en <= wb_dat_i[0];
    end else if (wr && wb_adr_i == 6'h14) begin
      sd_en <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_no_overlap: assert property (!(primary_o && compl_o))
    else $error("both drives on");
  a_shdn_map: assert property (shutdown_o == |(sd_en & ~shdn_src_i))
    else $error("shutdown mismatch");
  a_shdn_off: assert property (shutdown_o |=> !primary_o && !compl_o)
    else $error("drive during shutdown");
  a_dis_off: assert property (!en |=> !primary_o && !compl_o)
    else $error("drive while disabled");
  a_rise_cause: assert property ($rose(primary_o) |-> !$past(shutdown_o) && $past(en))
    else $error("primary rose without cause");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_rst_idle: assert property (disable iff (1'b0) rst_i |=> !primary_o && !compl_o)
    else $error("drive after reset");
endmodule // cdb_top_monitor

bind cdb_top cdb_top_monitor #(.W(W)) u_cdb_top_monitor (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .gen_in_i(gen_in_i),
  .shdn_src_i(shdn_src_i), .primary_o(primary_o), .compl_o(compl_o),
  .shutdown_o(shutdown_o)
);

// >>> tb/cdb_src_model.sv
// model of the on-chip event source and the shutdown sources
// assumes callers request changes; each lands just after a rising edge
`timescale 1ns/1ns

module cdb_src_model (
  input  wire logic       clk_i, // clock
  output logic            gen_o, // event level
  output logic      [7:0] src_o  // shutdown sources, high = healthy
);
  initial begin
    gen_o = 1'b0;
    src_o = 8'hff;
  end
  task put_gen(input logic v);
    @(posedge clk_i);
    gen_o <= v;
  endtask
  task put_src(input logic [7:0] v);
    @(posedge clk_i);
    src_o <= v;
  endtask
endmodule // cdb_src_model

// >>> tb/tb.sv
// self-checking bench: registers, dead band, overlap, blanking, shutdown
// assumes the source model drives the event input and shutdown sources
`timescale 1ns/1ns
`include "cdb_defines.vh"

module tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [3:0]  sel = 4'h0, wsel = 4'hf;
  wire  [31:0] rdat;
  wire         ack, gen, pri, cmp, shd;
  wire  [7:0]  src;
  int          errors = 0, n_tests = 0, cycles = 0, n;
  integer      seed = 32'h063e44a4;
  logic [31:0] q;
  logic [7:0]  v, e, s, r, f, d;
  initial forever #50 clk_i = ~clk_i;
  cdb_src_model u_cdb_src_model (.clk_i(clk_i), .gen_o(gen), .src_o(src));
  cdb_top #(.W(8)) u_cdb_top (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .gen_in_i(gen), .shdn_src_i(src), .primary_o(pri), .compl_o(cmp), .shutdown_o(shd));
  // ========
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [7:0] x);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, x};
    sel <= wsel;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task cfg(input logic ra, fa, input logic [7:0] rc, fc, dv);
    wb(1, `CDB_OFS_CTRL0, {5'h0, fa, ra, 1'b1});
    wb(1, `CDB_OFS_RISE_DB, rc);
    wb(1, `CDB_OFS_FALL_DB, fc);
    wb(1, `CDB_OFS_CLK_DIV, dv);
  endtask
  // earliest and latest cycle for the drive to rise, the one after the taking edge being 1
  function automatic int lo_d(logic a, int c, int dv);
    if (c == 0) return 1;
    if (a) return (c * 5 + 99) / 100 + 1;
    return (c - 1) * (dv + 1) + 2;
  endfunction
  function automatic int hi_d(logic a, int c, int dv);
    if (c == 0 || a) return lo_d(a, c, dv);
    return c * (dv + 1) + 1;
  endfunction
  task evt(input logic lvl, input int lo, input int hi);
    u_cdb_src_model.put_gen(lvl);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (n > 2) chk(lvl ? cmp : pri, 0);
    end while ((lvl ? pri : cmp) !== 1'b1 && n < 400);
    chk(n - 1 >= lo && n - 1 <= hi, 1);
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `CDB_OFS_SHDN_EN, 0);
    chk(q, 0);
    for (int i = 0; i < 7; i++) begin
      v = 8'($random(seed));
      wb(1, 6'(i * 4), v);
      wsel = 4'he;
      wb(1, 6'(i * 4), ~v);
      wsel = 4'hf;
      wb(0, 6'(i * 4), 0);
      chk(q, i == 0 ? {29'h0, v[2:0]} : {24'h0, v});
      wb(1, 6'(i * 4), 0);
    end
    wb(1, 6'h24, 8'hff);
    wb(0, 6'h24, 0);
    chk(q, 0);
    cfg(0, 0, 0, 0, 0);
    evt(1, 1, 1);
    evt(0, 1, 1);
    for (int k = 0; k < 24; k++) begin
      r = 8'({$random(seed)} % 41);
      f = 8'({$random(seed)} % 41);
      d = 8'({$random(seed)} % 4);
      cfg(k[0], k[1], r, f, d);
      evt(1, lo_d(k[0], r, d), hi_d(k[0], r, d));
      evt(0, lo_d(k[1], f, d), hi_d(k[1], f, d));
    end
    cfg(0, 0, 10, 3, 0);
    u_cdb_src_model.put_gen(1);
    repeat (4) begin @(negedge clk_i); chk(pri, 0); end
    evt(0, 4, 4);
    cfg(0, 0, 3, 10, 0);
    evt(1, 4, 4);
    u_cdb_src_model.put_gen(0);
    repeat (4) begin @(negedge clk_i); chk(cmp, 0); end
    evt(1, 4, 4);
    cfg(0, 0, 0, 0, 0);
    wb(1, `CDB_OFS_RISE_BLK, 8);
    evt(0, 1, 1);
    evt(1, 1, 1);
    u_cdb_src_model.put_gen(0);
    repeat (20) @(negedge clk_i);
    chk({pri, cmp}, 2'b10);
    u_cdb_src_model.put_gen(1);
    repeat (12) @(negedge clk_i);
    wb(1, `CDB_OFS_FALL_BLK, 8);
    evt(0, 1, 1);
    u_cdb_src_model.put_gen(1);
    repeat (20) @(negedge clk_i);
    chk({pri, cmp}, 2'b01);
    wb(0, `CDB_OFS_STATUS, 0);
    chk(q, 32'h0000_0001 << `CDB_ST_CMP);
    u_cdb_src_model.put_src(8'h00);
    @(negedge clk_i);
    chk(shd, 0);
    for (int k = 0; k < 40; k++) begin
      e = (k < 8) ? 8'h01 << k : 8'($random(seed));
      s = (k < 8) ? ~e : 8'($random(seed));
      wb(1, `CDB_OFS_SHDN_EN, e);
      u_cdb_src_model.put_src(s);
      @(negedge clk_i);
      chk(shd, |(e & ~s));
      if (|(e & ~s)) begin @(negedge clk_i); chk({pri, cmp}, 2'b00); end
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({pri, cmp, shd, ack}, 4'h0);
    wb(0, `CDB_OFS_SHDN_EN, 0);
    chk(q, 0);
    wrap_up();
  end
endmodule // tb
